// file: logic/sar_adc_sequencer.sv
// control of a 10-bit successive approximation converter
// assumes a sample-hold, a tap string driven by tap_code and a comparator
// whose output comp_ge is synchronous to clk and valid one bit period on
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/10ps
module sar_adc_sequencer
    import sar_adc_pkg::*;
#(
    parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DEF,
    parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // analog side
    input wire logic comp_ge,
    output analog_ctl_t analog,
    // event
    output logic conversion_done_irq
);

    generate
        if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 255) begin : g_bad_sample
            $error("SAMPLE_CYCLES must be 1 to 255");
        end
        if (BIT_CYCLES < 1 || BIT_CYCLES > 255) begin : g_bad_bit
            $error("BIT_CYCLES must be 1 to 255");
        end
    endgenerate

    localparam logic [CNT_W-1:0] SAMPLE_LOAD = CNT_W'(SAMPLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] BIT_LOAD = CNT_W'(BIT_CYCLES - 1);

    localparam seq_state_t STATE_RESET = '{
        st: ST_STOP,
        enable: 1'b0,
        start: 1'b0,
        res8: 1'b0,
        chan: CHAN_RESET,
        conv_chan: CHAN_RESET,
        sar: '0,
        idx: '0,
        cnt: '0,
        res_hi: RES_RESET,
        res_lo: RES_RESET,
        rdata: 8'h00,
        irq: 1'b0
    };

    seq_state_t state_reg;
    seq_state_t state_next;
    logic [9:0] decided;
    logic [3:0] last_bit;
    logic wr_mode0;
    logic busy;
    logic bit_end;

    assign last_bit = state_reg.res8 ? LAST_BIT_8 : LAST_BIT_10;
    assign wr_mode0 = wr && addr == ADDR_MODE0;
    assign busy = state_reg.st == ST_SAMPLE || state_reg.st == ST_TRIAL;
    assign bit_end = state_reg.st == ST_TRIAL && state_reg.cnt == '0;

    sar_bit_decide u_decide (
        .trial(state_reg.sar),
        .idx(state_reg.idx),
        .cmp_ge(comp_ge),
        .decided(decided)
    );

    always_comb begin
        state_next = state_reg;
        state_next.irq = 1'b0;
        state_next.rdata = 8'h00;

        // conversion progress
        unique case (state_reg.st)
            ST_STOP, ST_STANDBY: begin
            end
            ST_SAMPLE: begin
                if (state_reg.cnt == '0) begin
                    state_next.st = ST_TRIAL;
                    state_next.sar = SAR_HALF;
                    state_next.idx = TOP_BIT;
                    state_next.cnt = BIT_LOAD;
                end else begin
                    state_next.cnt = state_reg.cnt - 1'b1;
                end
            end
            ST_TRIAL: begin
                if (bit_end) begin
                    state_next.sar = decided;
                    if (state_reg.idx == last_bit) begin
                        // result moves and the interrupt fires together
                        state_next.res_hi = decided[9:2];
                        state_next.res_lo = state_reg.res8 ? 8'h00 :
                            {decided[1:0], RES_PAD'(0)};
                        state_next.irq = 1'b1;
                        state_next.start = 1'b0;
                        state_next.st = ST_STANDBY;
                    end else begin
                        state_next.idx = state_reg.idx - 4'h1;
                        state_next.cnt = BIT_LOAD;
                    end
                end else begin
                    state_next.cnt = state_reg.cnt - 1'b1;
                end
            end
            // a broken one-hot code restarts from stop
            default: begin
                state_next = STATE_RESET;
            end
        endcase

        // a mode0 write that clears start wins over the end-of-conversion update
        if (wr) begin
            unique case (addr)
                ADDR_MODE0: begin
                    state_next.enable = wdata[ENABLE_POS];
                    if (!wdata[START_POS]) begin
                        state_next.start = 1'b0;
                        if (busy) begin
                            state_next.st = ST_STANDBY;
                            state_next.res_hi = state_reg.res_hi;
                            state_next.res_lo = state_reg.res_lo;
                            state_next.irq = 1'b0;
                        end
                    end else if (state_reg.st == ST_STANDBY && state_reg.enable) begin
                        state_next.start = 1'b1;
                        state_next.st = ST_SAMPLE;
                        state_next.conv_chan = state_reg.chan;
                        state_next.cnt = SAMPLE_LOAD;
                    end
                end
                // channel changes during a conversion do not reach it
                ADDR_CHAN: state_next.chan = wdata[1:0];
                ADDR_MODE2: state_next.res8 = wdata[RES8_POS];
                default: begin
                end
            endcase
        end

        // enable moves between stop and standby
        if (state_next.st == ST_STOP && state_next.enable) begin
            state_next.st = ST_STANDBY;
        end else if (state_next.st == ST_STANDBY && !state_next.enable) begin
            state_next.st = ST_STOP;
        end

        if (rd) begin
            unique case (addr)
                ADDR_MODE0: state_next.rdata = {state_reg.start, 6'h00, state_reg.enable};
                ADDR_CHAN: state_next.rdata = {6'h00, state_reg.chan};
                ADDR_MODE2: state_next.rdata = {7'h00, state_reg.res8};
                ADDR_RES_HIGH: state_next.rdata = state_reg.res_hi;
                ADDR_RES_LOW: state_next.rdata = state_reg.res_lo;
                ADDR_STATUS: state_next.rdata = {7'h00, busy};
                default: state_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= STATE_RESET;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // analog controls come straight from state flops
    assign analog.sample_en = state_reg.st == ST_SAMPLE;
    assign analog.hold_en = state_reg.st == ST_TRIAL;
    assign analog.tap_code = state_reg.sar;

    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_chan
            // unused inputs stay off so they are not loaded while idle
            assign analog.input_sel[c] = busy && state_reg.conv_chan == 2'(c);
        end
    endgenerate

    assign rdata = state_reg.rdata;
    assign conversion_done_irq = state_reg.irq;

    a_reset_clears: assert property (
        @(posedge clk) !reset_n |=> state_reg.res_hi == 8'h00 && state_reg.res_lo == 8'h00)
        else $error("result not cleared by reset");

    a_sample_to_hold: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && state_reg.st == ST_SAMPLE && state_reg.cnt == '0 && !wr_mode0
        |=> analog.hold_en && !analog.sample_en && analog.tap_code == 10'h200
            && state_reg.idx == 4'h9)
        else $error("hold or half tap missing after sampling");

    a_start_needs_enable: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && wr_mode0 && wdata[7] && !state_reg.enable && !busy
        |=> !analog.sample_en && !state_reg.start)
        else $error("conversion started while disabled");

    a_enable_standby: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && state_reg.st == ST_STOP && wr_mode0 && wdata[0]
        |=> state_reg.st == ST_STANDBY)
        else $error("enable did not reach standby");

    a_done_standby: assert property (
        @(posedge clk) disable iff (!reset_n)
        conversion_done_irq && $past(ce)
        |-> (state_reg.st == ST_STANDBY || state_reg.st == ST_STOP) && !state_reg.start
            && $past(state_reg.st) == ST_TRIAL)
        else $error("done without return to standby");

    a_result_scale: assert property (
        @(posedge clk) disable iff (!reset_n)
        conversion_done_irq && !state_reg.res8
        |-> {state_reg.res_hi, state_reg.res_lo} == {state_reg.sar, 6'h00})
        else $error("result word is not trial value times 64");

    a_res8_low_zero: assert property (
        @(posedge clk) disable iff (!reset_n)
        conversion_done_irq && state_reg.res8 |-> state_reg.res_lo == 8'h00)
        else $error("low result not zero in 8-bit mode");

    a_abort_standby: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && busy && wr_mode0 && !wdata[7]
        |=> !busy && !conversion_done_irq && $stable(state_reg.res_hi))
        else $error("clearing start did not abandon conversion");

    a_bit_period: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && bit_end && state_reg.idx != last_bit && !wr_mode0
        |=> state_reg.idx == $past(state_reg.idx) - 4'h1 && analog.hold_en)
        else $error("trial did not step one bit down");

    a_trial_decides: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && bit_end
        |=> analog.tap_code[$past(state_reg.idx)] == $past(comp_ge))
        else $error("decided bit differs from comparator");

    a_next_tentative: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && bit_end && state_reg.idx != 4'h0
        |=> analog.tap_code[$past(state_reg.idx) - 4'h1])
        else $error("next trial bit not set");

    a_upper_kept: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && bit_end
        |=> ((analog.tap_code >> $past(state_reg.idx)) >> 1)
            == (($past(analog.tap_code) >> $past(state_reg.idx)) >> 1))
        else $error("decided upper bits changed");

    a_lower_clear: assert property (
        @(posedge clk) disable iff (!reset_n)
        state_reg.st == ST_TRIAL
        |-> analog.tap_code[state_reg.idx]
            && (analog.tap_code & ((10'h001 << state_reg.idx) - 10'h001)) == 10'h000)
        else $error("trial bit or lower bits wrong");

    a_hold_through: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && state_reg.st == ST_TRIAL && !bit_end && !wr_mode0
        |=> analog.hold_en && !analog.sample_en)
        else $error("hold dropped before conversion end");

    a_sample_count: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && state_reg.st == ST_SAMPLE && state_reg.cnt != '0 && !wr_mode0
        |=> analog.sample_en && state_reg.cnt == $past(state_reg.cnt) - 1'b1)
        else $error("sampling count did not step");

    a_start_loads: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && wr_mode0 && wdata[START_POS] && state_reg.st == ST_STANDBY && state_reg.enable
        |=> analog.sample_en && state_reg.start && state_reg.cnt == SAMPLE_LOAD
            && state_reg.conv_chan == $past(state_reg.chan))
        else $error("start did not begin sampling on the chosen channel");

    a_select_active: assert property (
        @(posedge clk) disable iff (!reset_n)
        busy |-> $onehot(analog.input_sel) && analog.input_sel[state_reg.conv_chan])
        else $error("input select not one-hot on the latched channel");

    a_select_idle: assert property (
        @(posedge clk) disable iff (!reset_n)
        !busy |-> analog.input_sel == 4'h0)
        else $error("input selected while idle");

    a_irq_pulse: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && conversion_done_irq |=> !conversion_done_irq)
        else $error("done interrupt longer than one cycle");

    a_result_held: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && !(bit_end && state_reg.idx == last_bit)
        |=> $stable(state_reg.res_hi) && $stable(state_reg.res_lo))
        else $error("result changed outside conversion end");

    a_done_high: assert property (
        @(posedge clk) disable iff (!reset_n)
        conversion_done_irq |-> state_reg.res_hi == state_reg.sar[9:2])
        else $error("high result is not the upper trial bits");

    a_stop_disable: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && state_reg.st == ST_STANDBY && wr_mode0 && !wdata[ENABLE_POS] && !wdata[START_POS]
        |=> state_reg.st == ST_STOP && !analog.sample_en)
        else $error("clearing enable in standby did not stop");

    a_trial_count: assert property (
        @(posedge clk) disable iff (!reset_n)
        conversion_done_irq && $past(ce)
        |-> $past(state_reg.idx) == ($past(state_reg.res8) ? LAST_BIT_8 : LAST_BIT_10))
        else $error("conversion ended on the wrong bit");

    a_collision_wins: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && wr_mode0 && !wdata[START_POS] && bit_end && state_reg.idx == last_bit
        |=> !conversion_done_irq && $stable(state_reg.res_hi) && $stable(state_reg.res_lo))
        else $error("mode write lost against conversion end");

endmodule

// file: logic/sar_adc_pkg.sv
// shared constants and types of the sar converter sequencer
// assumes one 50 MHz system clock and an 8-bit register port
package sar_adc_pkg;

    // register offsets on the plain register port
    localparam logic [2:0] ADDR_MODE0 = 3'h0;
    localparam logic [2:0] ADDR_CHAN = 3'h1;
    localparam logic [2:0] ADDR_MODE2 = 3'h2;
    localparam logic [2:0] ADDR_RES_HIGH = 3'h3;
    localparam logic [2:0] ADDR_RES_LOW = 3'h4;
    localparam logic [2:0] ADDR_STATUS = 3'h5;

    // field positions
    localparam int START_POS = 7;
    localparam int ENABLE_POS = 0;
    localparam int RES8_POS = 0;
    localparam int BUSY_POS = 0;

    // result layout and approximation
    localparam int SAR_W = 10;
    localparam int RES_PAD = 6;
    localparam logic [3:0] TOP_BIT = 4'h9;
    localparam logic [3:0] LAST_BIT_10 = 4'h0;
    localparam logic [3:0] LAST_BIT_8 = 4'h2;
    localparam logic [9:0] SAR_HALF = 10'h200;
    localparam int NUM_CH = 4;

    // reset values
    localparam logic [7:0] RES_RESET = 8'h00;
    localparam logic [1:0] CHAN_RESET = 2'h0;

    // timing defaults, in system clock cycles
    localparam int CLK_MHZ = 50;
    localparam int SAMPLE_NS = 160;
    localparam int SAMPLE_CYCLES_DEF = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
    localparam int BIT_CYCLES_DEF = 2;
    localparam int CNT_W = 8;

    typedef enum logic [3:0] {
        ST_STOP = 4'h1,
        ST_STANDBY = 4'h2,
        ST_SAMPLE = 4'h4,
        ST_TRIAL = 4'h8
    } conv_state_t;

    typedef struct packed {
        conv_state_t st;
        logic enable;
        logic start;
        logic res8;
        logic [1:0] chan;
        logic [1:0] conv_chan;
        logic [9:0] sar;
        logic [3:0] idx;
        logic [CNT_W-1:0] cnt;
        logic [7:0] res_hi;
        logic [7:0] res_lo;
        logic [7:0] rdata;
        logic irq;
    } seq_state_t;

    typedef struct packed {
        logic sample_en;
        logic hold_en;
        logic [3:0] input_sel;
        logic [9:0] tap_code;
    } analog_ctl_t;

endpackage

// file: logic/sar_bit_decide.sv
// decides one trial bit and sets the next one tentatively
// assumes idx names the bit under trial and cmp_ge is held >= tap
`timescale 1ns/10ps
module sar_bit_decide
    import sar_adc_pkg::*;
(
    // trial in
    input wire logic [9:0] trial,
    input wire logic [3:0] idx,
    input wire logic cmp_ge,
    // decided value out
    output logic [9:0] decided
);

    genvar b;
    generate
        for (b = 0; b < SAR_W; b++) begin : g_bit
            always_comb begin
                if (4'(b) > idx) begin
                    decided[b] = trial[b];
                end else if (4'(b) == idx) begin
                    decided[b] = cmp_ge;
                end else if (idx != 4'h0 && 4'(b) == idx - 4'h1) begin
                    decided[b] = 1'b1;
                end else begin
                    decided[b] = 1'b0;
                end
            end
        end
    endgenerate

endmodule

// file: dv/analog_front_model.sv
// behavioural sample-hold, tap string and comparator facing the sequencer
// assumes tap_code and hold_en come registered on clk
`timescale 1ns/10ps
module analog_front_model
    import sar_adc_pkg::*;
(
    // clock
    input wire logic clk,
    // input levels, in tap units
    input wire logic [3:0][9:0] level,
    // sequencer side
    input wire analog_ctl_t analog,
    output logic comp_ge
);
    logic [9:0] held_reg = 10'h000;
    logic idle_reg = 1'b0;
    // tracks the selected input while sampling, frozen once sampling stops
    always_ff @(posedge clk) begin
        idle_reg <= ~idle_reg;
        if (analog.sample_en) begin
            for (int i = 0; i < 4; i++) begin
                if (analog.input_sel[i]) begin
                    held_reg <= level[i];
                end
            end
        end
    end
    // no valid answer outside hold, so the output keeps moving
    assign comp_ge = analog.hold_en ? (held_reg >= analog.tap_code) : idle_reg;
endmodule

// file: dv/tb_top.sv
// self-checking bench of the sar converter sequencer
// assumes the analog model answers as an ideal >= comparator
`timescale 1ns/10ps
module tb_top;
    import sar_adc_pkg::*;
    localparam int SC = 3;
    localparam int BC = 2;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic comp_ge;
    analog_ctl_t analog;
    logic conversion_done_irq;
    logic [3:0][9:0] level = '0;
    logic [9:0] vals [6] = '{10'h2A7, 10'h000, 10'h3FF, 10'h200, 10'h1FF, 10'h155};
    int errors = 0;
    int n_checks = 0;
    int irq_cnt = 0;
    int irq_exp = 0;
    int wait_n = 0;
    logic [7:0] rv;

    sar_adc_sequencer #(.SAMPLE_CYCLES(SC), .BIT_CYCLES(BC)) u_sar_adc_sequencer (
        .clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .comp_ge(comp_ge), .analog(analog),
        .conversion_done_irq(conversion_done_irq));
    analog_front_model u_analog_front_model (
        .clk(clk), .level(level), .analog(analog), .comp_ge(comp_ge));

    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (conversion_done_irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // expected word is the held level times 64, low two bits dropped in 8-bit mode, ideal >= comparator
    task automatic convert(input int ch, input logic [9:0] v, input logic res8);
        int n;
        logic seen_hold;
        logic [15:0] word;
        n = 0;
        seen_hold = 1'b0;
        word = res8 ? {v[9:2], 8'h00} : {v, 6'h00};
        level[ch] = v;
        wr_reg(ADDR_CHAN, 8'(ch));
        wr_reg(ADDR_MODE2, {7'h00, res8});
        wr_reg(ADDR_MODE0, 8'h81);
        while (conversion_done_irq !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
            if (analog.hold_en === 1'b1 && !seen_hold) begin
                seen_hold = 1'b1;
                chk("hold delay", 16'(n), 16'(SC));
                chk("first tap", {6'h00, analog.tap_code}, {6'h00, SAR_HALF});
                chk("input select", {12'h000, analog.input_sel}, 16'h0001 << ch);
                chk("sample off", {15'h0, analog.sample_en}, 16'h0000);
            end else if (!seen_hold) begin
                chk("sample on", {15'h0, analog.sample_en}, 16'h0001);
            end
        end
        irq_exp++;
        chk("conversion time", 16'(n), 16'(SC + (res8 ? 8 : 10) * BC));
        chk("hold released", {15'h0, analog.hold_en}, 16'h0000);
        rd_reg(ADDR_RES_HIGH, rv);
        chk("result high", {8'h00, rv}, {8'h00, word[15:8]});
        rd_reg(ADDR_RES_LOW, rv);
        chk("result low", {8'h00, rv}, {8'h00, word[7:0]});
        rd_reg(ADDR_MODE0, rv);
        chk("start cleared", {8'h00, rv}, 16'h0001);
        chk("irq pulses", 16'(irq_cnt), 16'(irq_exp));
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rd_reg(ADDR_RES_HIGH, rv);
        chk("reset high", {8'h00, rv}, 16'h0000);
        rd_reg(ADDR_RES_LOW, rv);
        chk("reset low", {8'h00, rv}, 16'h0000);
        wr_reg(ADDR_RES_HIGH, 8'hFF);
        rd_reg(ADDR_RES_HIGH, rv);
        chk("read-only high", {8'h00, rv}, 16'h0000);
        rd_reg(3'h7, rv);
        chk("unmapped", {8'h00, rv}, 16'h0000);
        $display("test reset done");
        // start while stopped, and together with enable, both ignored
        wr_reg(ADDR_MODE0, 8'h80);
        wr_reg(ADDR_MODE0, 8'h00);
        wr_reg(ADDR_MODE0, 8'h81);
        repeat (40) @(posedge clk);
        rd_reg(ADDR_STATUS, rv);
        chk("disabled busy", {8'h00, rv}, 16'h0000);
        chk("disabled irq", 16'(irq_cnt), 16'h0000);
        $display("test disabled done");
        repeat (5) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            convert(i % 4, vals[i], i >= 4);
        end
        $display("test conversions done");
        // abort mid-trial
        wr_reg(ADDR_MODE0, 8'h81);
        repeat (6) @(posedge clk);
        wr_reg(ADDR_MODE0, 8'h01);
        repeat (40) @(posedge clk);
        rd_reg(ADDR_STATUS, rv);
        chk("abort busy", {8'h00, rv}, 16'h0000);
        chk("abort irq", 16'(irq_cnt), 16'(irq_exp));
        $display("test abort done");
        // mode write of zero taken on the completing edge
        level[0] = 10'h3FF;
        wr_reg(ADDR_CHAN, 8'h00);
        wr_reg(ADDR_MODE2, 8'h00);
        wr_reg(ADDR_MODE0, 8'h81);
        repeat (SC + 10 * BC - 2) @(posedge clk);
        wr_reg(ADDR_MODE0, 8'h00);
        repeat (10) @(posedge clk);
        chk("collision irq", 16'(irq_cnt), 16'(irq_exp));
        rd_reg(ADDR_RES_HIGH, rv);
        chk("collision high", {8'h00, rv}, {8'h00, vals[5][9:2]});
        rd_reg(ADDR_MODE0, rv);
        chk("collision mode", {8'h00, rv}, 16'h0000);
        $display("test collision done");
        // clock enable low in mid-trial stretches the conversion by as many cycles
        wr_reg(ADDR_MODE0, 8'h01);
        repeat (5) @(posedge clk);
        wr_reg(ADDR_MODE0, 8'h81);
        repeat (4) @(posedge clk);
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
        wait_n = 9;
        while (conversion_done_irq !== 1'b1 && wait_n < 200) begin
            @(posedge clk);
            #1;
            wait_n++;
        end
        irq_exp++;
        chk("frozen time", 16'(wait_n), 16'(SC + 10 * BC + 5));
        rd_reg(ADDR_RES_HIGH, rv);
        chk("frozen high", {8'h00, rv}, 16'h00FF);
        chk("frozen irq", 16'(irq_cnt), 16'(irq_exp));
        $display("test clock enable done");
        // disable from standby, then a start that must be ignored
        wr_reg(ADDR_MODE0, 8'h00);
        wr_reg(ADDR_MODE0, 8'h80);
        repeat (10) @(posedge clk);
        rd_reg(ADDR_STATUS, rv);
        chk("stopped busy", {8'h00, rv}, 16'h0000);
        rd_reg(ADDR_MODE0, rv);
        chk("stopped mode", {8'h00, rv}, 16'h0000);
        // reset in mid-run clears a nonzero result
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd_reg(ADDR_RES_HIGH, rv);
        chk("rerun reset high", {8'h00, rv}, 16'h0000);
        $display("test stop and reset done");
        report_and_stop();
    end

    // whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule
